// >>> logic/overflow_timer.sv
// Purpose: 8-bit up-counter with selectable tick, overflow flag and interrupt
// Assumes: one clock SYS_CLK at 100 MHz, synchronous active-high RST
// Notes: registers reached over APB; every top output comes from a flop
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps

// Notes on behaviour
// [RL1] count is 8 bits, plus one per tick
// [RL2] all flops on one clock, tick is enable
// [RL3] select zero means no tick, count holds
// [RL4] selects 1..5 give 1, 8, 64, 256, 1024
// [RL5] select 6 falling, 7 rising pin edges
// [RL6] pin edges count even when pin drives
// [RL7] count readable and writable at any time
// [RL8] software write beats a coincident tick
// [RL9] count only upward, FF wraps to 00
// [RL10] flag set in the wrapping tick cycle
// [RL11] counting only sets flag, entry clears it
// [RL12] irq when flag, enable and global set
// [RL13] flags shared register, each bit masked
// [RL14] write one clears flag, zero keeps it
// [RL15] pin sampled, edge detected, 2.5-3.5 delay; here 2 to 3 cycles from pin change to count
// [RL16] external clock half period over one cycle
// [RL17] reset clears count, select, flag, enable
// [RL18] overflow beats a coincident clear
module overflow_timer #(
  parameter int PRESCALE_W = timer_pkg::PRE_W
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [timer_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  input wire logic EXT_COUNT_PIN,
  input wire logic IRQ_ACK,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------

  // address to register selector, used by read and write paths
  function automatic timer_pkg::reg_sel_t decode(
    input logic [timer_pkg::ADDR_W-1:0] addr
  );
    timer_pkg::reg_sel_t sel;
    case (addr)
      timer_pkg::OFS_CONTROL: sel = timer_pkg::SEL_CONTROL;
      timer_pkg::OFS_COUNT: sel = timer_pkg::SEL_COUNT;
      timer_pkg::OFS_MASK: sel = timer_pkg::SEL_MASK;
      timer_pkg::OFS_FLAGS: sel = timer_pkg::SEL_FLAGS;
      default: sel = timer_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // true when the low n bits of the prescaler are all one
  function automatic logic tap_hit(
    input logic [PRESCALE_W-1:0] pre,
    input int n
  );
    logic hit;
    hit = 1'b1;
    for (int i = 0; i < PRESCALE_W; i++) begin
      if (i < n && !pre[i]) begin
        hit = 1'b0;
      end
    end
    return hit;
  endfunction : tap_hit

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  timer_pkg::apb_req_t req;
  timer_pkg::bus_state_t bus_state;
  timer_pkg::reg_sel_t sel;
  timer_pkg::clock_select_t clock_select;
  logic global_irq_enable;
  logic overflow_irq_enable;
  logic overflow_flag;
  logic [7:0] count_value;
  logic [PRESCALE_W-1:0] prescaler;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic timer_tick;
  logic commit;
  logic wr_commit;
  logic rd_commit;
  logic flag_clear;
  logic flag_set;
  logic read_flag_seen;
  logic [7:0] next_count;

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------

  // bundle the request for the decode and commit logic
  assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE,
                 addr: PADDR, wdata: PWDATA};
  assign sel = decode(req.addr);

  // transfer completes at the edge that samples PREADY high
  assign commit = req.sel && req.enable && PREADY;
  assign wr_commit = commit && req.write;
  assign rd_commit = commit && !req.write;

  // one wait state: answer raised in the second access cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      bus_state <= timer_pkg::ST_WAIT;
    end else begin
      case (bus_state)
        timer_pkg::ST_WAIT: begin
          if (req.sel && req.enable) begin
            bus_state <= timer_pkg::ST_ANSWER;
          end
        end
        timer_pkg::ST_ANSWER: bus_state <= timer_pkg::ST_WAIT;
        default: bus_state <= timer_pkg::ST_WAIT;
      endcase
    end
  end

  // ready and error flops are set at the same edge as the state change
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= (bus_state == timer_pkg::ST_WAIT) && req.sel && req.enable;
      PSLVERR <= (bus_state == timer_pkg::ST_WAIT) && req.sel && req.enable
                 && (sel == timer_pkg::SEL_NONE);
    end
  end

  // read data captured with the answer, held until the next answer
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (bus_state == timer_pkg::ST_WAIT && req.sel && req.enable) begin
      PRDATA <= 32'h0000_0000;
      if (!req.write) begin
        case (sel)
          timer_pkg::SEL_CONTROL: begin
            PRDATA[timer_pkg::CS_LSB +: timer_pkg::CS_W] <= clock_select;
            PRDATA[timer_pkg::GIE_BIT] <= global_irq_enable;
          end
          timer_pkg::SEL_COUNT: PRDATA[7:0] <= count_value; // RL7
          timer_pkg::SEL_MASK: PRDATA[timer_pkg::OVF_BIT] <= overflow_irq_enable;
          timer_pkg::SEL_FLAGS: PRDATA[timer_pkg::OVF_BIT] <= overflow_flag; // RL13
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // a read clears only the flag value that it actually returned
  assign read_flag_seen = rd_commit && (sel == timer_pkg::SEL_FLAGS)
                          && PRDATA[timer_pkg::OVF_BIT];

  // ----------------------------------------------------------------
  // control and mask registers
  // ----------------------------------------------------------------

  // clock select and global enable, written at commit
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      clock_select <= timer_pkg::CS_STOP; // RL17
      global_irq_enable <= 1'b0;
    end else if (wr_commit && sel == timer_pkg::SEL_CONTROL) begin
      clock_select <= timer_pkg::clock_select_t'(
        req.wdata[timer_pkg::CS_LSB +: timer_pkg::CS_W]);
      global_irq_enable <= req.wdata[timer_pkg::GIE_BIT];
    end
  end

  // overflow interrupt enable in the mask register
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      overflow_irq_enable <= 1'b0; // RL17
    end else if (wr_commit && sel == timer_pkg::SEL_MASK) begin
      overflow_irq_enable <= req.wdata[timer_pkg::OVF_BIT]; // RL13
    end
  end

  // ----------------------------------------------------------------
  // tick sources
  // ----------------------------------------------------------------

  // free-running shared prescaler, untouched by the clock select
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      prescaler <= '0;
    end else begin
      prescaler <= prescaler + PRESCALE_W'(1);
    end
  end

  // pin passes two flops, then a third for edge detection
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end else begin
      pin_meta <= EXT_COUNT_PIN; // RL15
      pin_sync <= pin_meta;
      pin_prev <= pin_sync; // RL6
    end
  end

  // tick selection, a one-cycle enable in the clock domain
  always_comb begin
    case (clock_select)
      timer_pkg::CS_STOP: timer_tick = 1'b0; // RL3
      timer_pkg::CS_DIV1: timer_tick = 1'b1; // RL4
      timer_pkg::CS_DIV8: timer_tick = tap_hit(prescaler, timer_pkg::TAP_8);
      timer_pkg::CS_DIV64: timer_tick = tap_hit(prescaler, timer_pkg::TAP_64);
      timer_pkg::CS_DIV256: timer_tick = tap_hit(prescaler, timer_pkg::TAP_256);
      timer_pkg::CS_DIV1024: timer_tick = tap_hit(prescaler, timer_pkg::TAP_1024);
      timer_pkg::CS_EXT_FALL: timer_tick = pin_prev && !pin_sync; // RL5
      timer_pkg::CS_EXT_RISE: timer_tick = !pin_prev && pin_sync; // RL5
      default: timer_tick = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------

  // software write first, then the increment, else hold
  always_comb begin
    if (wr_commit && sel == timer_pkg::SEL_COUNT) begin
      next_count = req.wdata[7:0]; // RL8
    end else if (timer_tick) begin
      next_count = count_value + timer_pkg::COUNT_ONE; // RL9
    end else begin
      next_count = count_value;
    end
  end

  // count register, enabled only by the tick or a write
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      count_value <= timer_pkg::COUNT_RST; // RL17
    end else begin
      count_value <= next_count; // RL1 RL2
    end
  end

  // ----------------------------------------------------------------
  // overflow flag and interrupt
  // ----------------------------------------------------------------

  // overflow is a tick at MAX not overridden by a count write
  assign flag_set = timer_tick && (count_value == timer_pkg::COUNT_MAX)
                    && !(wr_commit && sel == timer_pkg::SEL_COUNT); // RL10

  // write one, interrupt entry or a read of a set flag clears it
  assign flag_clear = (wr_commit && sel == timer_pkg::SEL_FLAGS
                       && req.wdata[timer_pkg::OVF_BIT]) // RL14
                      || IRQ_ACK // RL11
                      || read_flag_seen;

  // set wins over any clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      overflow_flag <= 1'b0; // RL17
    end else if (flag_set) begin
      overflow_flag <= 1'b1; // RL18
    end else if (flag_clear) begin
      overflow_flag <= 1'b0;
    end
  end

  // level interrupt, registered one cycle after the flag
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= overflow_flag && overflow_irq_enable && global_irq_enable; // RL12
    end
  end

endmodule : overflow_timer

// >>> logic/timer_pkg.sv
// Purpose: shared constants and types of the 8-bit overflow timer
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: offsets are byte addresses
package timer_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h0C;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CS_LSB = 0;
  localparam int CS_W = 3;
  localparam int GIE_BIT = 7;
  localparam int OVF_BIT = 0;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_ONE = 8'h01;

  // ----------------------------------------------------------------
  // prescaler taps, as the number of low bits that must all be one
  // ----------------------------------------------------------------
  localparam int PRE_W = 10;
  localparam int TAP_8 = 3;
  localparam int TAP_64 = 6;
  localparam int TAP_256 = 8;
  localparam int TAP_1024 = 10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CS_STOP = 3'h0,
    CS_DIV1 = 3'h1,
    CS_DIV8 = 3'h2,
    CS_DIV64 = 3'h3,
    CS_DIV256 = 3'h4,
    CS_DIV1024 = 3'h5,
    CS_EXT_FALL = 3'h6,
    CS_EXT_RISE = 3'h7
  } clock_select_t;

  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_ANSWER = 1'b1
  } bus_state_t;

  typedef enum logic [2:0] {
    SEL_CONTROL = 3'h0,
    SEL_COUNT = 3'h1,
    SEL_MASK = 3'h2,
    SEL_FLAGS = 3'h3,
    SEL_NONE = 3'h4
  } reg_sel_t;

  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } apb_req_t;

endpackage : timer_pkg

// >>> verif/overflow_timer_props.sv
// Purpose: port checker for the overflow timer
// Assumes: bound to overflow_timer, APB with one wait state
// Notes: the overflow flag is seen only through IRQ and reads
`timescale 1ns/1ps
module overflow_timer_props (
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [timer_pkg::ADDR_W-1:0] PADDR,
  input wire logic PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic PSLVERR,
  input wire logic IRQ_ACK,
  input wire logic IRQ
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // a commit or entry that may clear the flag or its enables
  logic clr;
  logic mapped;
  assign clr = IRQ_ACK | (PSEL & PENABLE & PREADY & (PADDR != timer_pkg::OFS_COUNT));
  assign mapped = PADDR inside {8'h00, 8'h04, 8'h08, 8'h0C};
  // ----------------------------------------------------------------
  // bus answer
  // ----------------------------------------------------------------
  one_wait_a: assert property ($rose(PENABLE) && PSEL |=> PREADY) else $error("late answer");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("answer too long");
  ready_cause_a: assert property (PREADY |-> $past(PSEL & PENABLE)) else $error("answer without access");
  slverr_map_a: assert property (PREADY |-> PSLVERR == !mapped) else $error("bad error answer");
  write_zero_a: assert property (PREADY && PWRITE |-> PRDATA == 32'h0) else $error("write data nonzero");
  rdata_hold_a: assert property (!PREADY |-> $stable(PRDATA)) else $error("read data moved");
  count_width_a: assert property (PREADY && !PWRITE && PADDR == timer_pkg::OFS_COUNT |->
    PRDATA[31:8] == 24'h0) else $error("count wider than eight bits");
  flag_width_a: assert property (PREADY && !PWRITE && PADDR == timer_pkg::OFS_FLAGS |->
    PRDATA[31:1] == 31'h0) else $error("stray flag bits");
  // ----------------------------------------------------------------
  // interrupt and reset
  // ----------------------------------------------------------------
  irq_fall_a: assert property ($fell(IRQ) |-> $past(clr) || $past(clr, 2)) else $error("irq fell uncleared");
  reset_quiet_a: assert property ($past(RST) |-> !PREADY && !IRQ && PRDATA == 32'h0) else $error("noisy reset");
  cover property ($rose(IRQ));
  cover property (PREADY && PSLVERR);
  cover property (IRQ_ACK && IRQ);
endmodule : overflow_timer_props

bind overflow_timer overflow_timer_props u_props (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PREADY, .PRDATA, .PSLVERR, .IRQ_ACK, .IRQ);

// >>> verif/overflow_timer_bench.sv
// Purpose: self-checking bench of the overflow timer
// Assumes: APB answer after one wait state, 100 MHz clock
// Notes: tick rates are judged by count deltas between reads
`timescale 1ns/1ps
module overflow_timer_bench;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic er;} row_t;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0, pin = 1'h0, ack = 1'h0;
  logic [7:0] addr = 8'h00, v;
  logic [31:0] wd = 32'h0, rd, prdata;
  logic prdy, perr, irq, err;
  int fail_count = 0, samples_checked = 0;
  logic [7:0] dlt [6] = '{8'h00, 8'h00, 8'h80, 8'h10, 8'h04, 8'h01};
  row_t rows [9] = '{'{1'h0, 8'h00, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h0, 1'h0},
    '{1'h0, 8'h08, 32'h0, 32'h0, 1'h0}, '{1'h0, 8'h0C, 32'h0, 32'h0, 1'h0},
    '{1'h1, 8'h04, 32'h5A, 32'h0, 1'h0}, '{1'h0, 8'h04, 32'h0, 32'h5A, 1'h0},
    '{1'h1, 8'h08, 32'hFF, 32'h0, 1'h0}, '{1'h0, 8'h08, 32'h0, 32'h1, 1'h0},
    '{1'h0, 8'h10, 32'h0, 32'h0, 1'h1}};
  overflow_timer dut (.SYS_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(addr),
    .PWDATA(wd), .PREADY(prdy), .PRDATA(prdata), .PSLVERR(perr), .EXT_COUNT_PIN(pin), .IRQ_ACK(ack), .IRQ(irq));
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwr <= w;
    addr <= a;
    wd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (prdy !== 1'h1);
    check(32'(n), 32'h2);
    rd = prdata;
    err = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  task automatic irq_is(input logic e);
    @(posedge clk);
    check({31'h0, irq}, {31'h0, e});
  endtask : irq_is
  // run four ticks from 0xFE, then stop; leaves count 0x02
  task automatic ovf(input logic [31:0] c);
    apb(1'h1, 8'h04, 32'hFE);
    apb(1'h1, 8'h00, c | 32'h1);
    apb(1'h1, 8'h00, c);
  endtask : ovf
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      check(rd, rows[i].e);
      check({31'h0, err}, {31'h0, rows[i].er});
    end
    // deltas over 1024 cycles for every internal select
    for (int cs = 0; cs < 6; cs++) begin
      apb(1'h1, 8'h00, 32'(cs));
      apb(1'h0, 8'h04, 32'h0);
      v = rd[7:0];
      repeat (1020) @(posedge clk);
      apb(1'h0, 8'h04, 32'h0);
      check({24'h0, 8'(rd[7:0] - v)}, {24'h0, dlt[cs]});
    end
    // tick every cycle so the count write meets a tick
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h04, 32'h33);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h04, 32'h0);
    check(rd, 32'h37);
    // pin goes up, down, up: two rises, one fall
    for (int m = 6; m < 8; m++) begin
      apb(1'h1, 8'h04, 32'h0);
      apb(1'h1, 8'h00, 32'(m));
      repeat (3) begin
        pin <= ~pin;
        repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
      apb(1'h0, 8'h04, 32'h0);
      check(rd, m == 6 ? 32'h1 : 32'h2);
      apb(1'h1, 8'h00, 32'h0);
      pin <= 1'h0;
      repeat (3) @(posedge clk);
    end
    // overflow, interrupt and the three ways to clear
    apb(1'h1, 8'h08, 32'h1);
    ovf(32'h80);
    apb(1'h0, 8'h04, 32'h0);
    check(rd, 32'h02);
    apb(1'h0, 8'h00, 32'h0);
    check(rd, 32'h80);
    irq_is(1'h1);
    apb(1'h1, 8'h0C, 32'h0);
    irq_is(1'h1);
    apb(1'h1, 8'h0C, 32'h1);
    irq_is(1'h0);
    ovf(32'h80);
    apb(1'h0, 8'h0C, 32'h0);
    check(rd, 32'h1);
    irq_is(1'h0);
    ovf(32'h80);
    ack <= 1'h1;
    @(posedge clk);
    ack <= 1'h0;
    @(posedge clk);
    irq_is(1'h0);
    apb(1'h1, 8'h08, 32'h0);
    ovf(32'h80);
    irq_is(1'h0);
    apb(1'h1, 8'h08, 32'h1);
    apb(1'h1, 8'h0C, 32'h1);
    ovf(32'h00);
    irq_is(1'h0);
    // wrap lands on the edge of a write-one clear: set must win
    apb(1'h1, 8'h00, 32'h1);
    apb(1'h1, 8'h04, 32'hFC);
    apb(1'h1, 8'h0C, 32'h1);
    apb(1'h1, 8'h00, 32'h0);
    apb(1'h0, 8'h0C, 32'h0);
    check(rd, 32'h1);
    // reset in mid-run
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    apb(1'h0, 8'h04, 32'h0);
    check(rd, 32'h0);
    final_report();
  end
  // watchdog, nearly five times the expected run
  initial begin
    repeat (30000) @(posedge clk);
    fail_count++;
    final_report();
  end
endmodule : overflow_timer_bench
